// file: hdl/csr_defines.vh
// Constants for the core status, option, port and reset register block.
// Assumes an instruction-cycle clock of 50 MHz on I_REF_CLK.
`ifndef CSR_DEFINES_VH
`define CSR_DEFINES_VH
// --------------------------------------------------------------------
// Register file addresses
// --------------------------------------------------------------------
`define CSR_ADDR_PCL     5'h02
`define CSR_ADDR_STATUS  5'h03
`define CSR_ADDR_REGULATED_IO_PORT   5'h05
`define CSR_ADDR_HIGH_VOLTAGE_IO_PORT   5'h06
`define CSR_CFG_ADDR     12'hFFF
// --------------------------------------------------------------------
// Status bit positions
// --------------------------------------------------------------------
`define CSR_ST_WAKE      7
`define CSR_ST_PG_HI     6
`define CSR_ST_PG_LO     5
`define CSR_ST_TO_N      4
`define CSR_ST_PD_N      3
`define CSR_ST_Z         2
`define CSR_ST_DC        1
`define CSR_ST_C         0
// --------------------------------------------------------------------
// Option bit positions and reset values
// --------------------------------------------------------------------
`define CSR_OPT_SRC      5
`define CSR_OPT_EDGE     4
`define CSR_OPT_PSA      3
`define CSR_OPT_RESET    6'h3F
`define CSR_DIR_RESET    8'hFF
`define CSR_PCL_RESET    8'hFF
`define CSR_OPT2_RESET   6'h3F
`define CSR_STATUS_POR   8'h98
`define CSR_DIRA_RESET   4'hF
`define CSR_TMR_DIV_POR  8'h00
`define CSR_WDT_DIV_POR  8'h80
// --------------------------------------------------------------------
// Configuration word fields
// --------------------------------------------------------------------
`define CSR_CFG_CP_MSB   11
`define CSR_CFG_CP_LSB   3
`define CSR_CFG_WDT      2
`define CSR_OSC_RC       2'h3
// --------------------------------------------------------------------
// Reset kinds
// --------------------------------------------------------------------
`define CSR_RK_MASTER_CLEAR_PIN      3'h0
`define CSR_RK_MASTER_CLEAR_PIN_WAKE 3'h1
`define CSR_RK_WDT       3'h2
`define CSR_RK_WDT_WAKE  3'h3
`define CSR_RK_PIN_WAKE  3'h4
`define CSR_RK_BROWNOUT  3'h5
// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define CSR_CLK_HZ       50000000
`define CSR_DRT_US       18000
`define CSR_DRT_RC_US    1000
`define CSR_DRT_CYCLES   ((`CSR_CLK_HZ / 1000000) * `CSR_DRT_US)
`define CSR_DRT_RC_CYC   ((`CSR_CLK_HZ / 1000000) * `CSR_DRT_RC_US)
`endif

// file: hdl/csr_core_regs.v
// Core status, option, port latch, direction and reset register block.
// Assumes the instruction decoder supplies single-cycle strobes on I_REF_CLK
// and that the timer, watchdog and sleep logic sit outside.
`timescale 1ns/1ns
`include "csr_defines.vh"

// Behaviour
// - Status as destination of a flag-updating instruction takes flags from ALU.
// - Software writes to time-out and power-down flags ignored; wake flag writable.
// - Clearing status clears upper three bits and sets zero flag.
// - Status holds two page preselect bits for larger program memory.
// - Option register is six bits, write-only, loaded from W by option instruction.
// - Every reset sets all six option bits.
// - Option bit 5 picks timer source: pin transitions or cycle clock.
// - Option bit 4 picks pin edge: one falling, zero rising.
// - Rate code gives timer 1:2 doubling; watchdog half that from 1:1.
// - Port bit set/clear reads pins, modifies one bit, writes all latches.
// - Port writes land at cycle end; port reads sample pins at cycle start.
// - Config bits 11..3 protect code when zero, allow verify when one.
// - Two config bits pick oscillator: RC, HS, XT, LP.
// - Watchdog disabled only by its fuse; runs on own RC oscillator.
// - Reset delay timer holds reset nominal 18 ms for crystal start.
// - Master clear wake gives status 1001 0uuu and program counter low all ones.
// - Watchdog wake gives status 1000 0uuu.
// - Pin wake gives 000u uuuu; brown-out gives page bits zero.
// - Master clear keeps time-out/power-down, clears pages; watchdog reset gives u000 1.
// - Watchdog clear instruction sets time-out and power-down flags.
// - Every reset and wake loads direction registers with all ones.
// - Sleep sets time-out flag, clears power-down flag, sets wake flag.
// - Pin-change wake clears the wake flag to mark its source.
module csr_core_regs #(
  parameter DRT_CYCLES = `CSR_DRT_CYCLES,
  parameter DRT_RC_CYCLES = `CSR_DRT_RC_CYC
) (
  // Clock and power-on reset
  input wire I_REF_CLK,
  input wire I_RST_N,
  // Reset and wake events from the reset circuit
  input wire I_DEV_RESET,
  input wire [2:0] I_RESET_KIND,
  // Instruction strobes from the decoder
  input wire I_FILE_WR,
  input wire [4:0] I_FILE_ADDR,
  input wire [7:0] I_FILE_WDATA,
  input wire I_ALU_FLAGS_UPD,
  input wire [2:0] I_ALU_FLAGS,
  input wire I_FILE_CLEAR,
  input wire I_BIT_OP,
  input wire I_BIT_SET,
  input wire [2:0] I_BIT_SEL,
  input wire I_OPTION_LOAD,
  input wire I_DIR_LOAD,
  input wire I_DIR_SEL_B,
  input wire [7:0] I_W_REG,
  input wire I_WDT_CLEAR,
  input wire I_SLEEP,
  input wire I_PCL_WR,
  input wire [7:0] I_PCL_NEXT,
  // Configuration word
  input wire [11:0] I_CONFIG_WORD,
  // Port pins
  input wire [3:0] I_REGULATED_IO_PORT_PIN,
  input wire [7:0] I_HIGH_VOLTAGE_IO_PORT_PIN,
  output reg [3:0] O_REGULATED_IO_PORT_OUT,
  output reg [3:0] O_REGULATED_IO_PORT_OE,
  output reg [7:0] O_HIGH_VOLTAGE_IO_PORT_OUT,
  output reg [7:0] O_HIGH_VOLTAGE_IO_PORT_OE,
  // Register read
  output reg [7:0] O_FILE_RDATA,
  output reg [7:0] O_STATUS,
  output reg [7:0] O_PCL,
  // Timer and prescaler controls
  output reg O_TMR_EXT_SRC,
  output reg O_TMR_FALL_EDGE,
  output reg O_PSC_TO_WDT,
  output reg [7:0] O_TMR_DIV,
  output reg [7:0] O_WDT_DIV,
  // Configuration decode
  output reg O_CODE_PROTECT,
  output reg [1:0] O_OSC_SEL,
  output reg O_WDT_ENABLE,
  // Reset delay
  output reg O_CORE_HOLD
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  reg [7:0] status_ff;
  reg [7:0] nxt_status;
  reg [5:0] option_ff;
  reg [3:0] regulated_io_port_lat_ff;
  reg [7:0] high_voltage_io_port_lat_ff;
  reg [3:0] dira_ff;
  reg [7:0] dirb_ff;
  reg [7:0] pcl_ff;
  reg [3:0] pa_meta_ff;
  reg [3:0] pa_sync_ff;
  reg [7:0] pb_meta_ff;
  reg [7:0] pb_sync_ff;
  reg [31:0] drt_cnt_ff;
  reg [3:0] nxt_regulated_io_port;
  reg [7:0] nxt_high_voltage_io_port;
  reg [7:0] regulated_io_port_mod;

  // Set or clear one bit of a byte
  function [7:0] bit_mod;
    input [7:0] val;
    input [2:0] sel;
    input setv;
    reg [7:0] tmp;
    begin
      tmp = val;
      tmp[sel] = setv;
      bit_mod = tmp;
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers; the second stage is the sampled pin value
  // ------------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pa_meta_ff <= 4'h0;
      pa_sync_ff <= 4'h0;
      pb_meta_ff <= 8'h00;
      pb_sync_ff <= 8'h00;
    end
    else
    begin
      pa_meta_ff <= I_REGULATED_IO_PORT_PIN;
      pa_sync_ff <= pa_meta_ff;
      pb_meta_ff <= I_HIGH_VOLTAGE_IO_PORT_PIN;
      pb_sync_ff <= pb_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // Status next value
  // ------------------------------------------------------------------
  always @*
  begin
    nxt_status = status_ff;
    if (I_DEV_RESET)
    begin
      nxt_status[`CSR_ST_PG_HI] = 1'b0;
      nxt_status[`CSR_ST_PG_LO] = 1'b0;
      case (I_RESET_KIND)
        `CSR_RK_MASTER_CLEAR_PIN_WAKE:
        begin
          nxt_status[`CSR_ST_WAKE] = 1'b1;
          nxt_status[`CSR_ST_TO_N] = 1'b1;
          nxt_status[`CSR_ST_PD_N] = 1'b0;
        end
        `CSR_RK_WDT:
        begin
          nxt_status[`CSR_ST_TO_N] = 1'b0;
          nxt_status[`CSR_ST_PD_N] = 1'b1;
        end
        `CSR_RK_WDT_WAKE:
        begin
          nxt_status[`CSR_ST_WAKE] = 1'b1;
          nxt_status[`CSR_ST_TO_N] = 1'b0;
          nxt_status[`CSR_ST_PD_N] = 1'b0;
        end
        `CSR_RK_PIN_WAKE:
        begin
          nxt_status[`CSR_ST_WAKE] = 1'b0;
        end
        default:
        begin
          nxt_status = status_ff & 8'h9F;
        end
      endcase
    end
    else
    begin
      if (I_FILE_CLEAR && I_FILE_ADDR == `CSR_ADDR_STATUS)
      begin
        nxt_status[7:5] = 3'h0;
        nxt_status[`CSR_ST_Z] = 1'b1;
      end
      else if (I_BIT_OP && I_FILE_ADDR == `CSR_ADDR_STATUS)
      begin
        nxt_status = bit_mod(status_ff, I_BIT_SEL, I_BIT_SET);
        nxt_status[`CSR_ST_TO_N] = status_ff[`CSR_ST_TO_N];
        nxt_status[`CSR_ST_PD_N] = status_ff[`CSR_ST_PD_N];
      end
      else if (I_FILE_WR && I_FILE_ADDR == `CSR_ADDR_STATUS)
      begin
        nxt_status[7:5] = I_FILE_WDATA[7:5];
        if (!I_ALU_FLAGS_UPD)
          nxt_status[2:0] = I_FILE_WDATA[2:0];
      end
      if (I_ALU_FLAGS_UPD)
        nxt_status[2:0] = I_ALU_FLAGS;
      if (I_WDT_CLEAR)
      begin
        nxt_status[`CSR_ST_TO_N] = 1'b1;
        nxt_status[`CSR_ST_PD_N] = 1'b1;
      end
      if (I_SLEEP)
      begin
        nxt_status[`CSR_ST_TO_N] = 1'b1;
        nxt_status[`CSR_ST_PD_N] = 1'b0;
        nxt_status[`CSR_ST_WAKE] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Port latch next values: read-modify-write uses synchronised pins
  // ------------------------------------------------------------------
  always @*
  begin
    nxt_regulated_io_port = regulated_io_port_lat_ff;
    nxt_high_voltage_io_port = high_voltage_io_port_lat_ff;
    regulated_io_port_mod = bit_mod({4'h0, pa_sync_ff}, I_BIT_SEL, I_BIT_SET);
    if (I_BIT_OP && I_FILE_ADDR == `CSR_ADDR_REGULATED_IO_PORT)
    begin
      nxt_regulated_io_port = regulated_io_port_mod[3:0];
    end
    else if (I_BIT_OP && I_FILE_ADDR == `CSR_ADDR_HIGH_VOLTAGE_IO_PORT)
    begin
      nxt_high_voltage_io_port = bit_mod(pb_sync_ff, I_BIT_SEL, I_BIT_SET);
    end
    else if (I_FILE_CLEAR && I_FILE_ADDR == `CSR_ADDR_REGULATED_IO_PORT)
      nxt_regulated_io_port = 4'h0;
    else if (I_FILE_CLEAR && I_FILE_ADDR == `CSR_ADDR_HIGH_VOLTAGE_IO_PORT)
      nxt_high_voltage_io_port = 8'h00;
    else if (I_FILE_WR && I_FILE_ADDR == `CSR_ADDR_REGULATED_IO_PORT)
      nxt_regulated_io_port = I_FILE_WDATA[3:0];
    else if (I_FILE_WR && I_FILE_ADDR == `CSR_ADDR_HIGH_VOLTAGE_IO_PORT)
      nxt_high_voltage_io_port = I_FILE_WDATA;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      status_ff <= `CSR_STATUS_POR;
      option_ff <= `CSR_OPT_RESET;
      regulated_io_port_lat_ff <= 4'h0;
      high_voltage_io_port_lat_ff <= 8'h00;
      dira_ff <= `CSR_DIRA_RESET;
      dirb_ff <= `CSR_DIR_RESET;
      pcl_ff <= `CSR_PCL_RESET;
    end
    else
    begin
      status_ff <= nxt_status;
      regulated_io_port_lat_ff <= nxt_regulated_io_port;
      high_voltage_io_port_lat_ff <= nxt_high_voltage_io_port;
      if (I_DEV_RESET)
      begin
        option_ff <= `CSR_OPT_RESET;
        dira_ff <= `CSR_DIRA_RESET;
        dirb_ff <= `CSR_DIR_RESET;
        pcl_ff <= `CSR_PCL_RESET;
      end
      else
      begin
        if (I_OPTION_LOAD)
          option_ff <= I_W_REG[5:0];
        if (I_DIR_LOAD && I_DIR_SEL_B)
          dirb_ff <= I_W_REG;
        else if (I_DIR_LOAD)
          dira_ff <= I_W_REG[3:0];
        if (I_PCL_WR)
          pcl_ff <= I_PCL_NEXT;
      end
    end
  end

  // ------------------------------------------------------------------
  // Reset delay timer, shortened when the RC oscillator is selected
  // ------------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      drt_cnt_ff <= 32'h0;
    else if (I_DEV_RESET)
      drt_cnt_ff <= (I_CONFIG_WORD[1:0] == `CSR_OSC_RC) ? DRT_RC_CYCLES : DRT_CYCLES;
    else if (drt_cnt_ff != 32'h0)
      drt_cnt_ff <= drt_cnt_ff - 32'h1;
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_REGULATED_IO_PORT_OUT <= 4'h0;
      O_REGULATED_IO_PORT_OE <= 4'h0;
      O_HIGH_VOLTAGE_IO_PORT_OUT <= 8'h00;
      O_HIGH_VOLTAGE_IO_PORT_OE <= 8'h00;
      O_FILE_RDATA <= 8'h00;
      O_STATUS <= `CSR_STATUS_POR;
      O_PCL <= `CSR_PCL_RESET;
      O_TMR_EXT_SRC <= 1'b1;
      O_TMR_FALL_EDGE <= 1'b1;
      O_PSC_TO_WDT <= 1'b1;
      O_TMR_DIV <= `CSR_TMR_DIV_POR;
      O_WDT_DIV <= `CSR_WDT_DIV_POR;
      O_CODE_PROTECT <= 1'b0;
      O_OSC_SEL <= 2'h0;
      O_WDT_ENABLE <= 1'b0;
      O_CORE_HOLD <= 1'b1;
    end
    else
    begin
      O_REGULATED_IO_PORT_OUT <= nxt_regulated_io_port;
      O_REGULATED_IO_PORT_OE <= ~dira_ff;
      O_HIGH_VOLTAGE_IO_PORT_OUT <= nxt_high_voltage_io_port;
      O_HIGH_VOLTAGE_IO_PORT_OE <= ~dirb_ff;
      // Reads sample the synchronised pins at cycle start
      if (I_FILE_ADDR == `CSR_ADDR_REGULATED_IO_PORT)
        O_FILE_RDATA <= {4'h0, pa_sync_ff};
      else if (I_FILE_ADDR == `CSR_ADDR_HIGH_VOLTAGE_IO_PORT)
        O_FILE_RDATA <= pb_sync_ff;
      else if (I_FILE_ADDR == `CSR_ADDR_STATUS)
        O_FILE_RDATA <= status_ff;
      else if (I_FILE_ADDR == `CSR_ADDR_PCL)
        O_FILE_RDATA <= pcl_ff;
      else
        O_FILE_RDATA <= 8'h00;
      O_STATUS <= nxt_status;
      O_PCL <= I_DEV_RESET ? `CSR_PCL_RESET : (I_PCL_WR ? I_PCL_NEXT : pcl_ff);
      O_TMR_EXT_SRC <= option_ff[`CSR_OPT_SRC];
      O_TMR_FALL_EDGE <= option_ff[`CSR_OPT_EDGE];
      O_PSC_TO_WDT <= option_ff[`CSR_OPT_PSA];
      O_TMR_DIV <= 8'h02 << option_ff[2:0];
      O_WDT_DIV <= 8'h01 << option_ff[2:0];
      O_CODE_PROTECT <= ~&I_CONFIG_WORD[`CSR_CFG_CP_MSB:`CSR_CFG_CP_LSB];
      O_OSC_SEL <= I_CONFIG_WORD[1:0];
      O_WDT_ENABLE <= I_CONFIG_WORD[`CSR_CFG_WDT];
      O_CORE_HOLD <= I_DEV_RESET || (drt_cnt_ff > 32'h1);
    end
  end

endmodule // csr_core_regs

// file: verif/csr_core_regs_chk.sv
// Assertion checker for the core status, option, port and reset registers.
// Assumes it is bound to csr_core_regs and sees only that module's ports.
`timescale 1ns/1ns
module csr_core_regs_chk #(
  parameter DRT_CYCLES = 20,
  parameter DRT_RC_CYCLES = 5
) (
  // Clock, reset and strobes
  input wire I_REF_CLK, I_RST_N, I_DEV_RESET, I_FILE_WR, I_ALU_FLAGS_UPD, I_FILE_CLEAR, I_BIT_OP,
  input wire I_OPTION_LOAD, I_WDT_CLEAR, I_SLEEP,
  input wire [2:0] I_RESET_KIND, I_ALU_FLAGS,
  input wire [4:0] I_FILE_ADDR,
  input wire [7:0] I_FILE_WDATA, I_W_REG,
  // Observed outputs
  input wire [7:0] O_STATUS, O_PCL, O_HIGH_VOLTAGE_IO_PORT_OUT, O_HIGH_VOLTAGE_IO_PORT_OE, O_TMR_DIV, O_WDT_DIV,
  input wire O_TMR_EXT_SRC, O_TMR_FALL_EDGE, O_PSC_TO_WDT, O_CORE_HOLD
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  wire q = !I_DEV_RESET && !I_SLEEP && !I_WDT_CLEAR && !I_FILE_CLEAR && !I_BIT_OP;
  wire st_wr = I_FILE_WR && I_FILE_ADDR == 5'h03;
  reg [31:0] hold_cnt_ff;
  always @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      hold_cnt_ff <= 32'h0;
    else if (O_CORE_HOLD)
      hold_cnt_ff <= hold_cnt_ff + 32'h1;
    else
      hold_cnt_ff <= 32'h0;
  end
  AST_ST_WR: assert property (q && st_wr |=> O_STATUS[4:3] == $past(O_STATUS[4:3])
    && O_STATUS[7] == $past(I_FILE_WDATA[7])) else $error("status write altered protected flags");
  AST_ALU_WINS: assert property (q && st_wr && I_ALU_FLAGS_UPD |=> O_STATUS[2:0] == $past(I_ALU_FLAGS))
    else $error("alu flags lost");
  AST_CLR_ST: assert property (I_FILE_CLEAR && I_FILE_ADDR == 5'h03 && !I_DEV_RESET && !I_SLEEP && !I_WDT_CLEAR
    && !I_ALU_FLAGS_UPD |=> O_STATUS[7:5] == 3'h0 && O_STATUS[2] && $stable(O_STATUS[4:3]))
    else $error("status clear wrong");
  AST_SLEEP: assert property (I_SLEEP && !I_DEV_RESET |=> O_STATUS[7] && O_STATUS[4:3] == 2'h2)
    else $error("sleep flags wrong");
  AST_WDT_CLR: assert property (I_WDT_CLEAR && !I_SLEEP && !I_DEV_RESET |=> O_STATUS[4:3] == 2'h3)
    else $error("watchdog clear flags wrong");
  AST_MASTER_CLEAR_PIN_WAKE: assert property (I_DEV_RESET && I_RESET_KIND == 3'h1 |=> O_STATUS[7:3] == 5'h12
    && O_PCL == 8'hFF) else $error("master clear wake state wrong");
  AST_WDT_WAKE: assert property (I_DEV_RESET && I_RESET_KIND == 3'h3 |=> O_STATUS[7:3] == 5'h10)
    else $error("watchdog wake state wrong");
  AST_PIN_WAKE: assert property (I_DEV_RESET && I_RESET_KIND == 3'h4 |=> O_STATUS[7:5] == 3'h0
    && O_STATUS[4:0] == $past(O_STATUS[4:0])) else $error("pin wake state wrong");
  AST_NORM_RST: assert property (I_DEV_RESET && I_RESET_KIND == 3'h0 |=> O_STATUS[6:5] == 2'h0
    && O_STATUS[4:3] == $past(O_STATUS[4:3])) else $error("master clear state wrong");
  AST_WDT_RST: assert property (I_DEV_RESET && I_RESET_KIND == 3'h2 |=> O_STATUS[6:3] == 4'h1)
    else $error("watchdog reset state wrong");
  AST_OPT_RST: assert property (I_DEV_RESET |=> ##1 O_TMR_EXT_SRC && O_TMR_FALL_EDGE && O_PSC_TO_WDT
    && O_HIGH_VOLTAGE_IO_PORT_OE == 8'h00) else $error("reset option or direction wrong");
  AST_OPT_LD: assert property (I_OPTION_LOAD && !I_DEV_RESET |=> ##1
    {O_TMR_EXT_SRC, O_TMR_FALL_EDGE, O_PSC_TO_WDT} == $past(I_W_REG[5:3], 2)) else $error("option load wrong");
  AST_DIV: assert property ($past(I_RST_N) |-> O_TMR_DIV == {O_WDT_DIV[6:0], 1'b0} && $onehot(O_WDT_DIV))
    else $error("prescaler divisions inconsistent");
  AST_PORT_WR: assert property (q && I_FILE_WR && I_FILE_ADDR == 5'h06 |=> O_HIGH_VOLTAGE_IO_PORT_OUT == $past(I_FILE_WDATA))
    else $error("port latch not written");
  AST_HOLD_MAX: assert property (hold_cnt_ff <= DRT_CYCLES + 1)
    else $error("reset hold too long");
endmodule // csr_core_regs_chk

bind csr_core_regs csr_core_regs_chk #(.DRT_CYCLES(DRT_CYCLES), .DRT_RC_CYCLES(DRT_RC_CYCLES)) chk_inst (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_DEV_RESET(I_DEV_RESET), .I_FILE_WR(I_FILE_WR),
  .I_ALU_FLAGS_UPD(I_ALU_FLAGS_UPD), .I_FILE_CLEAR(I_FILE_CLEAR), .I_BIT_OP(I_BIT_OP),
  .I_OPTION_LOAD(I_OPTION_LOAD), .I_WDT_CLEAR(I_WDT_CLEAR), .I_SLEEP(I_SLEEP), .I_RESET_KIND(I_RESET_KIND),
  .I_ALU_FLAGS(I_ALU_FLAGS), .I_FILE_ADDR(I_FILE_ADDR), .I_FILE_WDATA(I_FILE_WDATA), .I_W_REG(I_W_REG),
  .O_STATUS(O_STATUS), .O_PCL(O_PCL), .O_HIGH_VOLTAGE_IO_PORT_OUT(O_HIGH_VOLTAGE_IO_PORT_OUT), .O_HIGH_VOLTAGE_IO_PORT_OE(O_HIGH_VOLTAGE_IO_PORT_OE),
  .O_TMR_DIV(O_TMR_DIV), .O_WDT_DIV(O_WDT_DIV), .O_TMR_EXT_SRC(O_TMR_EXT_SRC),
  .O_TMR_FALL_EDGE(O_TMR_FALL_EDGE), .O_PSC_TO_WDT(O_PSC_TO_WDT), .O_CORE_HOLD(O_CORE_HOLD)
);

// file: verif/csr_core_regs_test.sv
// Self-checking testbench for the core status, option, port and reset registers.
// Assumes short reset delay counts; inputs change on the falling clock edge.
`timescale 1ns/1ns
module csr_core_regs_test;
  logic clk = 0, rst_n = 0, dev_rst = 0, fwr = 0, aupd = 0, fclr = 0, bop = 0, bset = 0;
  logic oload = 0, dload = 0, dselb = 0, wclr = 0, slp = 0, pwr = 0;
  logic [2:0] kind = 0, aflg = 0, bsel = 0;
  logic [4:0] addr = 0;
  logic [7:0] wdat = 0, w = 0, pnext = 0, pb = 0, st, program_counter_low_byte, pbo, pboe, rdat, tdiv, wdiv, s, e, m;
  logic [11:0] cfg = 12'hFFF;
  logic [3:0] pa = 0, pao, paoe;
  logic ext, fall, psw, cprot, wen, hold;
  logic [1:0] osc;
  int i, n, bad_count = 0, n_tests = 0;
  csr_core_regs #(.DRT_CYCLES(20), .DRT_RC_CYCLES(5)) csr_core_regs_inst (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_DEV_RESET(dev_rst), .I_RESET_KIND(kind), .I_FILE_WR(fwr),
    .I_FILE_ADDR(addr), .I_FILE_WDATA(wdat), .I_ALU_FLAGS_UPD(aupd), .I_ALU_FLAGS(aflg), .I_FILE_CLEAR(fclr),
    .I_BIT_OP(bop), .I_BIT_SET(bset), .I_BIT_SEL(bsel), .I_OPTION_LOAD(oload), .I_DIR_LOAD(dload),
    .I_DIR_SEL_B(dselb), .I_W_REG(w), .I_WDT_CLEAR(wclr), .I_SLEEP(slp), .I_PCL_WR(pwr), .I_PCL_NEXT(pnext),
    .I_CONFIG_WORD(cfg), .I_REGULATED_IO_PORT_PIN(pa), .I_HIGH_VOLTAGE_IO_PORT_PIN(pb), .O_REGULATED_IO_PORT_OUT(pao), .O_REGULATED_IO_PORT_OE(paoe),
    .O_HIGH_VOLTAGE_IO_PORT_OUT(pbo), .O_HIGH_VOLTAGE_IO_PORT_OE(pboe), .O_FILE_RDATA(rdat), .O_STATUS(st), .O_PCL(program_counter_low_byte),
    .O_TMR_EXT_SRC(ext), .O_TMR_FALL_EDGE(fall), .O_PSC_TO_WDT(psw), .O_TMR_DIV(tdiv), .O_WDT_DIV(wdiv),
    .O_CODE_PROTECT(cprot), .O_OSC_SEL(osc), .O_WDT_ENABLE(wen), .O_CORE_HOLD(hold)
  );
  always #10 clk = ~clk;
  task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Strobes last one cycle; one idle cycle lets late outputs settle
  task step;
    @(negedge clk);
    {dev_rst, fwr, aupd, fclr, bop, oload, dload, wclr, slp, pwr} = '0;
    @(negedge clk);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    end_of_test;
  end
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    step;
    chk("status after power-up", 8'h98, st);
    chk("pcl after power-up", 8'hFF, program_counter_low_byte);
    for (i = 0; i < 8; i++)
    begin
      w = {2'b00, i[0], ~i[1], i[2], i[2:0]};
      oload = 1;
      step;
      chk("option bits", {5'h0, w[5:3]}, {5'h0, ext, fall, psw});
      chk("timer division", 8'(2 << i), tdiv);
      chk("watchdog division", 8'(1 << i), wdiv);
    end
    for (i = 0; i < 4; i++)
    begin
      cfg = {i[0] ? 9'h1FF : 9'h1EF, i[1], i[1:0]};
      step;
      chk("code protect", {7'h0, ~i[0]}, {7'h0, cprot});
      chk("osc and watchdog fuse", {5'h0, i[1], i[1:0]}, {5'h0, wen, osc});
    end
    slp = 1;
    step;
    chk("sleep", 8'h90, st);
    addr = 5'h03;
    wdat = 8'hFF;
    fwr = 1;
    step;
    chk("status write", 8'hF7, st);
    fclr = 1;
    step;
    chk("status clear", 8'h17, st);
    wdat = 8'h00;
    aflg = 3'h5;
    fwr = 1;
    aupd = 1;
    step;
    chk("alu flags win", 8'h15, st);
    wclr = 1;
    step;
    chk("watchdog clear", 8'h1D, st);
    chk("status read", 8'h1D, rdat);
    for (i = 0; i < 6; i++)
    begin
      w = 8'h00;
      wdat = 8'hE5;
      pnext = 8'h12;
      dselb = i[0];
      {fwr, slp, oload, dload, pwr} = '1;
      step;
      s = st;
      m = (i == 5) ? 8'h60 : 8'hFF;
      case (i)
        0: e = {s[7], 2'b00, s[4:0]};
        1: e = {5'h12, s[2:0]};
        2: e = {s[7], 4'h1, s[2:0]};
        3: e = {5'h10, s[2:0]};
        4: e = {3'h0, s[4:0]};
        default: e = 8'h00;
      endcase
      cfg = {10'h3FF, i[0] ? 2'h3 : 2'h1};
      kind = 3'(i);
      dev_rst = 1;
      step;
      chk("status after reset kind", e, st & m);
      chk("pcl after reset", 8'hFF, program_counter_low_byte);
      chk("direction after reset", 8'h01, {paoe, pboe[7:5], psw & ext & fall});
      n = 0;
      while (hold === 1'b1 && n < 100)
      begin
        @(negedge clk);
        n++;
      end
      chk("reset delay", 8'h1, {7'h0, n + 1 >= (i[0] ? 5 : 20) && n <= (i[0] ? 5 : 20)});
    end
    pb = 8'hC3;
    pa = 4'hA;
    dselb = 1;
    w = 8'h0F;
    dload = 1;
    step;
    chk("port b drive enable", 8'hF0, pboe);
    addr = 5'h06;
    {bop, bset, bsel} = {2'b11, 3'h5};
    step;
    chk("bit set on port", 8'hE3, pbo);
    {bop, bset, bsel} = {2'b10, 3'h7};
    step;
    chk("bit clear on port", 8'h43, pbo);
    addr = 5'h05;
    {bop, bset, bsel} = {2'b11, 3'h0};
    step;
    chk("bit set on port a", 8'h0B, {4'h0, pao});
    addr = 5'h06;
    wdat = 8'h5A;
    fwr = 1;
    step;
    chk("port latch", 8'h5A, pbo);
    chk("port pin read", 8'hC3, rdat);
    addr = 5'h07;
    step;
    chk("unmapped read", 8'h00, rdat);
    end_of_test;
  end
endmodule // csr_core_regs_test
